// ---- core/mms_pkg.sv ----
// Package: constants and carrier types for the memory-space map block
package mms_pkg;
  // Program space
  localparam int PROG_ADDR_W = 12;
  localparam logic [11:0] PROG_LAST = 12'hfff;
  // Program map regions (user vectors at top, factory test below)
  localparam logic [11:0] TEST_AREA_FIRST = 12'hf00;
  localparam logic [11:0] TEST_AREA_LAST = 12'hfef;
  localparam logic [11:0] VEC_FIRST = 12'hff0;
  localparam logic [11:0] RESET_VEC = 12'hffe;
  localparam logic [11:0] NMI_VEC = 12'hffc;
  // Data space decode
  localparam logic [7:0] RAM_FIRST = 8'h00;
  localparam logic [7:0] RAM_LAST = 8'h3f;
  localparam logic [7:0] WIN_FIRST = 8'h40;
  localparam logic [7:0] WIN_LAST = 8'h7f;
  localparam logic [7:0] REG_FIRST = 8'h80;
  localparam logic [7:0] WIN_SEL_ADDR = 8'hc9;
  localparam logic [7:0] ACC_ADDR = 8'hff;
  localparam int WIN_OFS_W = 6;
  localparam int WIN_BLK_W = 6;
  localparam logic [7:0] WIN_SEL_MASK = 8'h3f;
  // Stack
  localparam int STACK_DEPTH = 6;
  localparam logic [2:0] STACK_LAST = 3'h5;
  // Ports
  localparam int PORT_BITS = 12;
  localparam logic [11:0] PORT_RESET_DIR = 12'h000;
  localparam logic [11:0] PORT_RESET_PULL = 12'hfff;
  // Closed-read value when readout is protected
  localparam logic [7:0] PROTECT_FILL = 8'h00;

  // Access kind selects the space, not the address
  typedef enum logic [3:0] {
    MMS_ACC_NONE  = 4'h1,
    MMS_ACC_FETCH = 4'h2,
    MMS_ACC_DATA  = 4'h4,
    MMS_ACC_STACK = 4'h8
  } mms_kind_type;

  typedef enum logic [2:0] {
    MMS_RUN  = 3'h1,
    MMS_PROG = 3'h2,
    MMS_HOLD = 3'h4
  } mms_mode_type;

  typedef enum logic [2:0] {
    MMS_ZONE_RAM = 3'h1,
    MMS_ZONE_WIN = 3'h2,
    MMS_ZONE_REG = 3'h4
  } mms_zone_type;

  // Core request
  typedef struct packed {
    mms_kind_type kind;
    logic wr;
    logic push;
    logic pop;
    logic [11:0] progAddr;
    logic [7:0] dataAddr;
    logic [7:0] wdata;
    logic [11:0] retAddr;
  } mms_req_type;

  // Answer back to the core
  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic [11:0] retAddr;
    logic stackFull;
    logic stackEmpty;
  } mms_rsp_type;

  // Memory/peripheral side request
  typedef struct packed {
    logic progRd;
    logic [11:0] progAddr;
    logic ramRd;
    logic ramWr;
    logic regRd;
    logic regWr;
    logic [7:0] dataAddr;
    logic [7:0] wdata;
  } mms_mem_type;
endpackage : mms_pkg

// ---- core/mms_edge_detect.sv ----
// Falling-edge catcher for the non-maskable interrupt pin
`timescale 1ns/1ps
module mms_edge_detect
  import mms_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pinLevel,
  input wire logic ack,
  output logic pending
);
  typedef struct packed {
    logic last;
    logic pend;
  } mms_edge_state_type;

  mms_edge_state_type state_reg;
  mms_edge_state_type state_next;

  // Edge sets, acknowledge clears, set wins
  always_comb begin
    state_next = state_reg;
    state_next.last = pinLevel;
    if (ack) begin
      state_next.pend = 1'b0;
    end
    if (state_reg.last && !pinLevel) begin
      state_next.pend = 1'b1;
    end
  end

  // Last level starts high so a pin low at reset counts as a falling edge on the first clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{last: 1'b1, pend: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pending = state_reg.pend;
endmodule : mms_edge_detect

// ---- core/mms_return_stack.sv ----
// Six-level hardware return-address stack
`timescale 1ns/1ps
module mms_return_stack
  import mms_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [11:0] pushAddr,
  output logic [11:0] topAddr,
  output logic full,
  output logic empty
);
  typedef struct packed {
    logic [STACK_DEPTH-1:0][11:0] level;
    logic [2:0] count;
  } mms_stack_state_type;

  mms_stack_state_type state_reg;
  mms_stack_state_type state_next;

  // Shift-register stack; a push when full drops the oldest entry
  always_comb begin
    state_next = state_reg;
    if (push) begin
      for (int i = STACK_DEPTH - 1; i > 0; i--) begin
        state_next.level[i] = state_reg.level[i-1];
      end
      state_next.level[0] = pushAddr;
      if (state_reg.count != STACK_LAST + 3'h1) begin
        state_next.count = state_reg.count + 3'h1;
      end
    end else if (pop) begin
      for (int i = 0; i < STACK_DEPTH - 1; i++) begin
        state_next.level[i] = state_reg.level[i+1];
      end
      state_next.level[STACK_DEPTH-1] = 12'h000;
      if (state_reg.count != 3'h0) begin
        state_next.count = state_reg.count - 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign topAddr = state_reg.level[0];
  assign full = (state_reg.count == STACK_LAST + 3'h1);
  assign empty = (state_reg.count == 3'h0);
endmodule : mms_return_stack

// ---- core/mms_space_map.sv ----
// Memory-space map: program, data and stack decode, ROM window, protection, pin reset state
// Behaviour
// - A high-to-low edge on the interrupt pin registers a non-maskable request, its level does not; a pin already low at reset also counts as an edge.
// - The active-low reset pin is the highest priority event, above every interrupt, and cannot be masked.
// - After reset every port pin is an input with pull-up until software reconfigures it.
// - Programming mode is entered instead of normal operation when the programming level is present during reset.
// - Program, data and stack storage are three separate spaces chosen by access kind, not by address.
// - The stack holds six return addresses shared by calls and interrupt entries.
// - Fetches use a 12-bit program counter reaching 4K bytes.
// - Program space holds code, immediate operands, a factory test region and the user vectors.
// - With the readout-protection bit set, every external read of program memory is blocked.
// - Readout protection is cleared only by a full erase that also wipes the program memory.
// - Data space maps user RAM, core and peripheral registers, and constants from program memory.
// - Constant reads go through a 64-byte data-space window, each location one program byte.
// - The register part of data space holds accumulator, index, short direct, port, peripheral, option and window-select registers.
// - The window occupies data addresses 0040h to 007Fh.
// - A write-only window-select register picks the 64-byte block; its reset value is undefined, so software loads it first.
`timescale 1ns/1ps
module mms_space_map
  import mms_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // Pins
  input wire logic resetPinN,
  input wire logic nmiPin,
  input wire logic progLevelHigh,
  // Option bit and erase indication from the memory array, and the external programmer read strobe
  input wire logic readoutProtect,
  input wire logic fullErase,
  input wire logic externalRead,
  // Core side
  input mms_req_type coreReq,
  input wire logic nmiAck,
  input wire logic [11:0] portDirWr,
  input wire logic [11:0] portPullWr,
  input wire logic portCfgWr,
  output mms_rsp_type coreRsp,
  output logic resetReq,
  output logic nmiReq,
  output logic [11:0] programCounter,
  output logic testAreaFetch,
  output logic vectorFetch,
  // Memory side
  input wire logic [7:0] progRdata,
  input wire logic [7:0] ramRdata,
  input wire logic [7:0] regRdata,
  output mms_mem_type memReq,
  output logic [7:0] externalRdata,
  output logic externalBlocked,
  // Mode and port configuration
  output logic programMode,
  output logic [11:0] portOutEnable,
  output logic [11:0] pullupInputState
);
  // Block state other than the stack and edge catcher in one register; non-stack outputs read it directly
  typedef struct packed {
    mms_mode_type mode;
    logic resetReq;
    logic protectLatched;
    logic [WIN_BLK_W-1:0] romWindowSelect;
    logic [11:0] programCounter;
    logic testFetch;
    logic vecFetch;
    mms_zone_type pendZone;
    logic pendData;
    logic pendStack;
    logic pendExt;
    logic rspValid;
    logic [7:0] rspData;
    mms_mem_type mem;
    logic [7:0] extData;
    logic extBlocked;
    logic nmiOut;
    logic progOut;
    logic [11:0] dirOut;
    logic [11:0] pullOn;
  } mms_state_type;

  mms_state_type state_reg;
  mms_state_type state_next;
  logic nmiPending;
  logic stackPush;
  logic stackPop;
  logic [11:0] stackTop;
  logic stackFull;
  logic stackEmpty;
  mms_zone_type zone;
  logic running;

  // Pin edge catcher; pending holds until acknowledged
  mms_edge_detect u_nmi (
    .clk(clk),
    .rst(rst),
    .pinLevel(nmiPin),
    .ack(nmiAck),
    .pending(nmiPending)
  );

  // Stack only moves on stack-kind accesses in normal operation
  assign running = (state_reg.mode == MMS_RUN);
  assign stackPush = running && (coreReq.kind == MMS_ACC_STACK) && coreReq.push;
  assign stackPop = running && (coreReq.kind == MMS_ACC_STACK) && coreReq.pop && !coreReq.push;

  // Return stack shared by calls and interrupt entries
  mms_return_stack u_stack (
    .clk(clk),
    .rst(rst),
    .push(stackPush),
    .pop(stackPop),
    .pushAddr(coreReq.retAddr),
    .topAddr(stackTop),
    .full(stackFull),
    .empty(stackEmpty)
  );

  // Data address decode into RAM, window and register zones
  always_comb begin
    if (coreReq.dataAddr <= RAM_LAST) begin
      zone = MMS_ZONE_RAM;
    end else if (coreReq.dataAddr >= WIN_FIRST && coreReq.dataAddr <= WIN_LAST) begin
      zone = MMS_ZONE_WIN;
    end else begin
      zone = MMS_ZONE_REG;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    state_next = state_reg;
    state_next.mem = '0;
    state_next.rspValid = 1'b0;
    state_next.testFetch = 1'b0;
    state_next.vecFetch = 1'b0;
    state_next.pendData = 1'b0;
    state_next.pendStack = 1'b0;
    state_next.pendExt = 1'b0;

    // Reset pin overrides mode, ports, counter and core fetch and data requests, and cannot be masked
    state_next.resetReq = !resetPinN;
    if (!resetPinN) begin
      // Mode is sampled while reset is held, then kept
      state_next.mode = progLevelHigh ? MMS_PROG : MMS_HOLD;
      state_next.dirOut = PORT_RESET_DIR;
      state_next.pullOn = PORT_RESET_PULL;
      state_next.programCounter = RESET_VEC;
    end else begin
      if (state_reg.mode == MMS_HOLD) begin
        state_next.mode = MMS_RUN;
      end
      // Pins stay input with pull-up until software writes them
      if (running && portCfgWr) begin
        state_next.dirOut = portDirWr;
        state_next.pullOn = portPullWr;
      end
      // Fetch goes through the 12-bit counter
      if (running && coreReq.kind == MMS_ACC_FETCH) begin
        state_next.programCounter = coreReq.progAddr;
        state_next.mem.progRd = 1'b1;
        state_next.mem.progAddr = coreReq.progAddr;
        state_next.testFetch = (coreReq.progAddr >= TEST_AREA_FIRST) && (coreReq.progAddr <= TEST_AREA_LAST);
        state_next.vecFetch = (coreReq.progAddr >= VEC_FIRST);
        state_next.pendZone = MMS_ZONE_WIN;
        state_next.pendData = 1'b1;
      end else if (running && coreReq.kind == MMS_ACC_DATA) begin
        // Address and data go out for every zone
        state_next.mem.dataAddr = coreReq.dataAddr;
        state_next.mem.wdata = coreReq.wdata;
        state_next.pendZone = zone;
        unique case (zone)
          MMS_ZONE_RAM: begin
            // User RAM answers in the strobe cycle
            state_next.mem.ramRd = !coreReq.wr;
            state_next.mem.ramWr = coreReq.wr;
            state_next.pendData = !coreReq.wr;
          end
          MMS_ZONE_WIN: begin
            // Window is read-only; writes are dropped
            state_next.mem.progRd = !coreReq.wr;
            state_next.mem.progAddr = {state_reg.romWindowSelect,
                                       coreReq.dataAddr[WIN_OFS_W-1:0]};
            state_next.pendData = !coreReq.wr;
          end
          MMS_ZONE_REG: begin
            // Window select is write-only and holds block number only
            if (coreReq.wr && coreReq.dataAddr == WIN_SEL_ADDR) begin
              state_next.romWindowSelect = coreReq.wdata[WIN_BLK_W-1:0];
            end
            state_next.mem.regRd = !coreReq.wr;
            state_next.mem.regWr = coreReq.wr;
            state_next.pendData = !coreReq.wr;
          end
          default: begin
            state_next.pendData = 1'b0;
          end
        endcase
      end else if (stackPop) begin
        state_next.pendStack = 1'b1;
      end
    end

    // Answer one cycle after the memory request
    if (state_reg.pendData) begin
      state_next.rspValid = 1'b1;
      unique case (state_reg.pendZone)
        MMS_ZONE_RAM: begin
          state_next.rspData = ramRdata;
        end
        MMS_ZONE_WIN: begin
          // Fetches share this path, both read program memory
          state_next.rspData = progRdata;
        end
        MMS_ZONE_REG: begin
          state_next.rspData = regRdata;
        end
        default: begin
          state_next.rspData = 8'h00;
        end
      endcase
    end else if (state_reg.pendStack) begin
      state_next.rspValid = 1'b1;
    end

    // Protection latch: set by option bit, only a full erase clears it
    if (fullErase) begin
      state_next.protectLatched = 1'b0;
    end
    if (readoutProtect && !fullErase) begin
      state_next.protectLatched = 1'b1;
    end

    // External programmer reads, only in programming mode
    state_next.extBlocked = 1'b0;
    if (state_reg.mode == MMS_PROG && externalRead) begin
      if (state_reg.protectLatched || readoutProtect) begin
        state_next.extBlocked = 1'b1;
        state_next.extData = PROTECT_FILL;
      end else begin
        state_next.mem.progRd = 1'b1;
        state_next.mem.progAddr = coreReq.progAddr;
        state_next.pendExt = 1'b1;
      end
    end
    // Byte is taken in its strobe cycle, while memory answers
    if (state_reg.pendExt) begin
      state_next.extData = progRdata;
    end
    // Registered copies so these two outputs leave a flip-flop
    // A held reset pin silences the interrupt request
    state_next.nmiOut = nmiPending && resetPinN;
    state_next.progOut = (state_next.mode == MMS_PROG);
  end

  // Window select has no defined reset value; cleared here only for X-free simulation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{
        mode: MMS_HOLD,
        resetReq: 1'b1,
        protectLatched: 1'b0,
        romWindowSelect: '0,
        programCounter: RESET_VEC,
        testFetch: 1'b0,
        vecFetch: 1'b0,
        pendZone: MMS_ZONE_RAM,
        pendData: 1'b0,
        pendStack: 1'b0,
        pendExt: 1'b0,
        rspValid: 1'b0,
        rspData: 8'h00,
        mem: '0,
        extData: 8'h00,
        extBlocked: 1'b0,
        nmiOut: 1'b0,
        progOut: 1'b0,
        dirOut: PORT_RESET_DIR,
        pullOn: PORT_RESET_PULL
      };
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from registers, except stack full and empty, which are decoded from the stack count
  assign coreRsp.valid = state_reg.rspValid;
  assign coreRsp.rdata = state_reg.rspData;
  assign coreRsp.retAddr = stackTop;
  assign coreRsp.stackFull = stackFull;
  assign coreRsp.stackEmpty = stackEmpty;
  assign resetReq = state_reg.resetReq;
  assign nmiReq = state_reg.nmiOut;
  assign programCounter = state_reg.programCounter;
  assign testAreaFetch = state_reg.testFetch;
  assign vectorFetch = state_reg.vecFetch;
  assign memReq = state_reg.mem;
  assign externalRdata = state_reg.extData;
  assign externalBlocked = state_reg.extBlocked;
  assign programMode = state_reg.progOut;
  assign portOutEnable = state_reg.dirOut;
  assign pullupInputState = state_reg.pullOn;
endmodule : mms_space_map

// ---- sim/mms_mem_model.sv ----
// Memory and peripheral model behind the space map's memory-side strobes
`timescale 1ns/1ps
module mms_mem_model
  import mms_pkg::*;
(
  input wire logic clk,
  input mms_mem_type memReq,
  output logic [7:0] progRdata,
  output logic [7:0] ramRdata,
  output logic [7:0] regRdata
);
  logic [7:0] ramArr [64];
  logic [7:0] junk = 8'h00;
  // Idle buses churn, so a stale value never passes for an answer
  always @(posedge clk) junk <= junk + 8'h3b;
  // RAM keeps what is written
  always @(posedge clk) if (memReq.ramWr) ramArr[memReq.dataAddr[5:0]] <= memReq.wdata;
  // Answers during the strobe cycle; program byte is a scramble of its address
  assign progRdata = memReq.progRd ? (memReq.progAddr[7:0] ^ {2{memReq.progAddr[11:8]}}) : junk;
  assign ramRdata = memReq.ramRd ? ramArr[memReq.dataAddr[5:0]] : junk;
  assign regRdata = memReq.regRd ? (memReq.dataAddr ^ 8'h5a) : junk;
endmodule : mms_mem_model

// ---- sim/mms_space_map_assertions.sv ----
// Concurrent checks on the space map ports
`timescale 1ns/1ps
module mms_space_map_assertions
  import mms_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic resetPinN,
  input wire logic nmiPin,
  input wire logic nmiAck,
  input wire logic progLevelHigh,
  input wire logic readoutProtect,
  input wire logic fullErase,
  input wire logic externalRead,
  input wire logic portCfgWr,
  input mms_req_type coreReq,
  input mms_rsp_type coreRsp,
  input mms_mem_type memReq,
  input logic resetReq,
  input logic nmiReq,
  input logic testAreaFetch,
  input logic [7:0] externalRdata,
  input logic externalBlocked,
  input logic programMode,
  input logic [11:0] portOutEnable,
  input logic [11:0] pullupInputState
);
  logic [1:0] upCnt;
  logic live;
  // Cycles since the reset pin went high; margin past the hold-to-run step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) upCnt <= 2'h0;
    else if (!resetPinN) upCnt <= 2'h0;
    else if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
  end
  assign live = (upCnt == 2'h3) && !programMode;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_win;
    coreReq.kind == MMS_ACC_DATA && !coreReq.wr && coreReq.dataAddr[7:6] == 2'b01 && live
      |=> memReq.progRd && memReq.progAddr[5:0] == $past(coreReq.dataAddr[5:0]) ##1 coreRsp.valid;
  endproperty
  a_win: assert property (p_win) else $error("window read not sent to program memory");
  property p_winwr;
    coreReq.kind == MMS_ACC_DATA && coreReq.wr && coreReq.dataAddr[7:6] == 2'b01 && live
      |=> !memReq.ramWr && !memReq.regWr;
  endproperty
  a_winwr: assert property (p_winwr) else $error("window write not dropped");
  property p_fetch;
    coreReq.kind == MMS_ACC_FETCH && live
      |=> memReq.progRd && memReq.progAddr == $past(coreReq.progAddr) ##1 coreRsp.valid;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address not passed whole");
  property p_ram;
    coreReq.kind == MMS_ACC_DATA && coreReq.dataAddr[7:6] == 2'b00 && live
      |=> !memReq.progRd && (memReq.ramRd || memReq.ramWr);
  endproperty
  a_ram: assert property (p_ram) else $error("low data address not sent to RAM");
  property p_area;
    coreReq.kind == MMS_ACC_FETCH && live && coreReq.progAddr >= 12'hf00 && coreReq.progAddr <= 12'hfef
      |-> ##[1:2] testAreaFetch;
  endproperty
  a_area: assert property (p_area) else $error("test area fetch not flagged");
  property p_nmi;
    $fell(nmiPin) && live && !nmiAck |-> ##[1:3] nmiReq;
  endproperty
  a_nmi: assert property (p_nmi) else $error("falling edge gave no interrupt request");
  property p_rst;
    !resetPinN |=> resetReq && !nmiReq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pin not above interrupt");
  property p_port;
    !resetPinN |=> portOutEnable == 12'h000 && pullupInputState == 12'hfff;
  endproperty
  a_port: assert property (p_port) else $error("ports not input with pull-up in reset");
  property p_keep;
    resetPinN && !$past(portCfgWr) |-> $stable(portOutEnable) && $stable(pullupInputState);
  endproperty
  a_keep: assert property (p_keep) else $error("port setup changed without a write");
  property p_prog;
    !resetPinN && progLevelHigh |-> ##[1:2] programMode;
  endproperty
  a_prog: assert property (p_prog) else $error("programming level in reset gave no mode");
  property p_block;
    programMode && externalRead && readoutProtect && $past(readoutProtect) && !fullErase && !$past(fullErase)
      |=> externalBlocked && externalRdata == 8'h00;
  endproperty
  a_block: assert property (p_block) else $error("protected read not blocked");
endmodule : mms_space_map_assertions
bind mms_space_map mms_space_map_assertions mms_space_map_assertions_inst (.clk(clk), .rst(rst),
  .resetPinN(resetPinN), .nmiPin(nmiPin), .nmiAck(nmiAck), .progLevelHigh(progLevelHigh),
  .readoutProtect(readoutProtect), .fullErase(fullErase), .externalRead(externalRead), .portCfgWr(portCfgWr),
  .coreReq(coreReq), .coreRsp(coreRsp), .memReq(memReq), .resetReq(resetReq), .nmiReq(nmiReq),
  .testAreaFetch(testAreaFetch), .externalRdata(externalRdata), .externalBlocked(externalBlocked),
  .programMode(programMode), .portOutEnable(portOutEnable), .pullupInputState(pullupInputState));

// ---- sim/mms_space_map_bench.sv ----
// Self-checking bench for the memory-space map
`timescale 1ns/1ps
module mms_space_map_bench
  import mms_pkg::*;
();
  logic clk = 1'b0, rst = 1'b1, resetPinN = 1'b0, nmiPin = 1'b1, nmiAck = 1'b0, progLevelHigh = 1'b0;
  logic readoutProtect = 1'b0, fullErase = 1'b0, externalRead = 1'b0, portCfgWr = 1'b0;
  logic [11:0] portDirWr = 12'h000, portPullWr = 12'h000, programCounter, portOutEnable, pullupInputState;
  logic [7:0] progRdata, ramRdata, regRdata, externalRdata;
  logic resetReq, nmiReq, externalBlocked, programMode, testAreaFetch, vectorFetch;
  logic [1:0] flg;
  logic [15:0] lfsr = 16'hf7c9;
  logic [11:0] fa [7] = '{12'h000, 12'h7a5, 12'hf00, 12'hfef, 12'hff0, 12'hffe, 12'hfff};
  logic [11:0] stk [$];
  mms_req_type coreReq;
  mms_rsp_type coreRsp;
  mms_mem_type memReq;
  int fails = 0, compares = 0, sel, ofs, a, d;
  int ramM [64];
  int aq [$];
  mms_space_map mms_space_map_inst (.clk(clk), .rst(rst), .resetPinN(resetPinN), .nmiPin(nmiPin),
    .progLevelHigh(progLevelHigh), .readoutProtect(readoutProtect), .fullErase(fullErase),
    .externalRead(externalRead), .coreReq(coreReq), .nmiAck(nmiAck), .portDirWr(portDirWr),
    .portPullWr(portPullWr), .portCfgWr(portCfgWr), .coreRsp(coreRsp), .resetReq(resetReq), .nmiReq(nmiReq),
    .programCounter(programCounter), .testAreaFetch(testAreaFetch), .vectorFetch(vectorFetch),
    .progRdata(progRdata),
    .ramRdata(ramRdata), .regRdata(regRdata), .memReq(memReq), .externalRdata(externalRdata),
    .externalBlocked(externalBlocked), .programMode(programMode), .portOutEnable(portOutEnable),
    .pullupInputState(pullupInputState));
  mms_mem_model mms_mem_model_inst (.clk(clk), .memReq(memReq), .progRdata(progRdata), .ramRdata(ramRdata),
    .regRdata(regRdata));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Expected program byte, same scramble the memory model stores
  function automatic logic [7:0] pb(input logic [11:0] x);
    return x[7:0] ^ {2{x[11:8]}};
  endfunction : pb
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdChk(input logic [7:0] e);
    chk("valid", 12'h001, {11'h0, coreRsp.valid});
    chk("rdata", {4'h0, e}, {4'h0, coreRsp.rdata});
  endtask : rdChk
  // One request, taken at the next edge; returns in the cycle its answer stands
  task automatic go(input mms_kind_type k, input logic w, input logic [1:0] pp, input logic [11:0] pa,
    input logic [7:0] da, input logic [7:0] dd);
    coreReq = '{kind: k, wr: w, push: pp[1], pop: pp[0], progAddr: pa, dataAddr: da, wdata: dd, retAddr: pa};
    tick(1);
    flg = {testAreaFetch, vectorFetch};
    coreReq = '{kind: MMS_ACC_NONE, default: '0};
    tick(1);
  endtask : go
  task automatic ext(input logic [11:0] x, input logic bl);
    coreReq.progAddr = x;
    externalRead = 1'b1;
    tick(1);
    externalRead = 1'b0;
    chk("blocked", {11'h0, bl}, {11'h0, externalBlocked});
    tick(1);
    chk("extdata", bl ? {4'h0, PROTECT_FILL} : {4'h0, pb(x)}, {4'h0, externalRdata});
  endtask : ext
  task automatic end_of_test();
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  // Watchdog far beyond the roughly 160 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
  // Main sequence
  initial begin
    coreReq = '{kind: MMS_ACC_NONE, default: '0};
    tick(5);
    rst = 1'b0;
    tick(1);
    chk("resetReq", 12'h001, {11'h0, resetReq});
    chk("counter", 12'hffe, programCounter);
    chk("pull", 12'hfff, pullupInputState);
    resetPinN = 1'b1;
    tick(3);
    chk("dir", 12'h000, portOutEnable);
    chk("mode", 12'h000, {11'h0, programMode});
    // Window blocks at both offset edges and random ones
    for (int i = 0; i < 4; i++) begin
      sel = rnd() & 16'h3f;
      go(MMS_ACC_DATA, 1'b1, 2'b00, 12'h000, 8'hc9, sel[7:0]);
      for (int j = 0; j < 4; j++) begin
        ofs = (j == 0) ? 0 : (j == 1) ? 63 : rnd() & 16'h3f;
        go(MMS_ACC_DATA, 1'b0, 2'b00, 12'h000, 8'h40 + ofs[7:0], 8'h00);
        rdChk(pb({sel[5:0], ofs[5:0]}));
      end
    end
    go(MMS_ACC_DATA, 1'b1, 2'b00, 12'h000, 8'h45, 8'hff);
    go(MMS_ACC_DATA, 1'b0, 2'b00, 12'h000, 8'h45, 8'h00);
    rdChk(pb({sel[5:0], 6'h05}));
    // RAM written then read back, kept apart from the window
    for (int i = 0; i < 8; i++) begin
      a = rnd() & 16'h3f;
      d = rnd() & 16'hff;
      ramM[a] = d;
      aq.push_back(a);
      go(MMS_ACC_DATA, 1'b1, 2'b00, 12'h000, a[7:0], d[7:0]);
    end
    foreach (aq[i]) begin
      go(MMS_ACC_DATA, 1'b0, 2'b00, 12'h000, aq[i][7:0], 8'h00);
      rdChk(ramM[aq[i]][7:0]);
    end
    go(MMS_ACC_DATA, 1'b0, 2'b00, 12'h000, 8'hff, 8'h00);
    rdChk(8'ha5);
    foreach (fa[i]) begin
      go(MMS_ACC_FETCH, 1'b0, 2'b00, fa[i], 8'h00, 8'h00);
      rdChk(pb(fa[i]));
      chk("counter", fa[i], programCounter);
      chk("area", {11'h0, fa[i] >= TEST_AREA_FIRST && fa[i] <= TEST_AREA_LAST}, {11'h0, flg[1]});
      chk("vector", {11'h0, fa[i] >= VEC_FIRST}, {11'h0, flg[0]});
    end
    // Seven pushes overflow six levels, then six pops empty it
    for (int i = 0; i < 7; i++) begin
      a = rnd() & 16'hfff;
      stk.push_front(a[11:0]);
      if (stk.size() > 6) stk = stk[0:5];
      go(MMS_ACC_STACK, 1'b0, 2'b10, a[11:0], 8'h00, 8'h00);
      chk("top", stk[0], coreRsp.retAddr);
    end
    chk("full", 12'h001, {11'h0, coreRsp.stackFull});
    for (int i = 0; i < 6; i++) begin
      void'(stk.pop_front());
      go(MMS_ACC_STACK, 1'b0, 2'b01, 12'h000, 8'h00, 8'h00);
      chk("top", stk.size() > 0 ? stk[0] : 12'h000, coreRsp.retAddr);
    end
    chk("empty", 12'h001, {11'h0, coreRsp.stackEmpty});
    a = rnd() & 16'hfff;
    portDirWr = a[11:0];
    portPullWr = ~a[11:0];
    portCfgWr = 1'b1;
    tick(1);
    portCfgWr = 1'b0;
    chk("dir", a[11:0], portOutEnable);
    chk("pull", ~a[11:0], pullupInputState);
    // Edge, acknowledge, then a held low level must stay quiet
    nmiPin = 1'b0;
    tick(3);
    chk("nmi", 12'h001, {11'h0, nmiReq});
    nmiAck = 1'b1;
    tick(1);
    nmiAck = 1'b0;
    tick(3);
    chk("nmi", 12'h000, {11'h0, nmiReq});
    nmiPin = 1'b1;
    tick(1);
    nmiPin = 1'b0;
    tick(3);
    resetPinN = 1'b0;
    progLevelHigh = 1'b1;
    tick(3);
    chk("nmi", 12'h000, {11'h0, nmiReq});
    chk("pull", 12'hfff, pullupInputState);
    chk("mode", 12'h001, {11'h0, programMode});
    resetPinN = 1'b1;
    tick(3);
    ext(12'h123, 1'b0);
    readoutProtect = 1'b1;
    tick(2);
    ext(12'h456, 1'b1);
    readoutProtect = 1'b0;
    tick(2);
    ext(12'h789, 1'b1);
    fullErase = 1'b1;
    tick(2);
    fullErase = 1'b0;
    tick(2);
    ext(12'habc, 1'b0);
    end_of_test();
  end
endmodule : mms_space_map_bench
